// [hw/rate_gen_pkg.sv]
// Register map, field positions, reset values and multiplier shifts for the rate generator
package rate_gen_pkg;
	localparam int ADDR_W = 8;
	// Byte offsets of the register words
	localparam logic [7:0] OFS_BAUD_CONTROL = 8'h00;
	localparam logic [7:0] OFS_RECEIVE_STATUS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_RATE_DIVISOR_LOW = 8'h08;
	localparam logic [7:0] OFS_RATE_DIVISOR_HIGH = 8'h0c;
	localparam logic [7:0] OFS_TRANSMIT_STATUS_CONTROL = 8'h10;
	localparam logic [7:0] OFS_RATE_COUNT_STATUS = 8'h14;
	// baud_control fields
	localparam int BIT_RECEIVER_IDLE = 6;
	localparam int BIT_CLOCK_POLARITY = 4;
	localparam int BIT_WIDE_COUNTER = 3;
	localparam int BIT_WAKE_ENABLE = 1;
	localparam int BIT_AUTO_RATE_ENABLE = 0;
	localparam logic [7:0] BAUD_CONTROL_WMASK = 8'h1b;
	localparam logic [7:0] BAUD_CONTROL_RESET = 8'h00;
	// receive_status_control fields
	localparam int BIT_PORT_ENABLE = 7;
	localparam logic [7:0] RECEIVE_STATUS_CONTROL_WMASK = 8'hf8;
	localparam logic [7:0] RECEIVE_STATUS_CONTROL_RESET = 8'h00;
	// transmit_status_control fields
	localparam int BIT_CLOCK_SOURCE = 7;
	localparam int BIT_SYNC_MODE = 4;
	localparam int BIT_HIGH_SPEED = 2;
	localparam int BIT_SHIFT_EMPTY = 1;
	localparam logic [7:0] TRANSMIT_STATUS_CONTROL_WMASK = 8'hfd;
	localparam logic [7:0] TRANSMIT_STATUS_CONTROL_RESET = 8'h00;
	localparam logic [7:0] DIVISOR_RESET = 8'h00;
	// Prescale shifts: M = 2**shift
	localparam logic [2:0] SHIFT_M64 = 3'h6;
	localparam logic [2:0] SHIFT_M16 = 3'h4;
	localparam logic [2:0] SHIFT_M4 = 3'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hw/rate_cfg_if.sv]
// Configuration and status carried between the register block and the rate counter
`timescale 1ns/10ps
interface rate_cfg_if;
	logic [15:0] divisor;
	logic wide_counter_select;
	logic high_speed_select;
	logic sync_mode_select;
	logic clear;
	logic [15:0] count;
	logic tick;
	logic clock_level;
	modport regs (output divisor, wide_counter_select, high_speed_select, sync_mode_select, clear,
		input count, tick, clock_level);
	modport counter (input divisor, wide_counter_select, high_speed_select, sync_mode_select, clear,
		output count, tick, clock_level);
endinterface

// [hw/rate_counter.sv]
// Free-running prescaler and divisor counter producing the bit-rate tick
`timescale 1ns/10ps
module rate_counter (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Configuration and status
	rate_cfg_if.counter cfg
);
	logic [5:0] pre;
	logic [15:0] count;
	logic tick;
	logic clock_level;
	wire logic [2:0] shift = cfg.sync_mode_select ? rate_gen_pkg::SHIFT_M4 :
		cfg.wide_counter_select ? (cfg.high_speed_select ? rate_gen_pkg::SHIFT_M4 : rate_gen_pkg::SHIFT_M16) :
		(cfg.high_speed_select ? rate_gen_pkg::SHIFT_M16 : rate_gen_pkg::SHIFT_M64);
	wire logic [5:0] pre_last = 6'((7'h01 << shift) - 7'h01);
	// Only the low byte counts in 8-bit mode
	wire logic [15:0] n_eff = cfg.wide_counter_select ? cfg.divisor : {8'h00, cfg.divisor[7:0]};
	wire logic pre_wrap = (pre == pre_last);
	wire logic count_wrap = pre_wrap && (count >= n_eff);
	// Position inside the bit period, compared with half the period for the serial clock duty
	wire logic [22:0] position = 23'((23'(count) << shift) | 23'(pre));
	wire logic [22:0] half_period = 23'((24'(n_eff) + 24'h000001) << (shift - 3'h1));
	wire logic next_clock_level = (position < half_period);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre <= 6'h00;
			count <= 16'h0000;
			tick <= 1'b0;
			clock_level <= 1'b0;
		end else if (cfg.clear) begin
			pre <= 6'h00;
			count <= 16'h0000;
			tick <= 1'b0;
			clock_level <= 1'b0;
		end else begin
			pre <= pre_wrap ? 6'h00 : 6'(pre + 6'h01);
			count <= count_wrap ? 16'h0000 : (pre_wrap ? 16'(count + 16'h0001) : count);
			tick <= count_wrap;
			clock_level <= next_clock_level;
		end
	end

	assign cfg.count = count;
	assign cfg.tick = tick;
	assign cfg.clock_level = clock_level;
endmodule // rate_counter

// [hw/serial_clock_pin.sv]
// Serial clock pin: drives the generated clock as master, synchronises the pin as slave
`timescale 1ns/10ps
module serial_clock_pin (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Selection
	input wire logic master,
	input wire logic invert,
	input wire logic generated_level,
	// Pin
	input wire logic clock_pin_in,
	output logic clock_pin_out,
	output logic clock_pin_oe,
	// Clock level seen by the shifters
	output logic serial_clock
);
	logic pin_meta;
	logic pin_sync;
	logic drive;
	logic level_out;

	// Pin is asynchronous, so two flops before use
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			drive <= 1'b0;
			level_out <= 1'b0;
		end else begin
			pin_meta <= clock_pin_in;
			pin_sync <= pin_meta;
			drive <= master;
			level_out <= generated_level ^ invert;
		end
	end

	assign clock_pin_out = level_out;
	assign clock_pin_oe = drive;
	assign serial_clock = drive ? level_out : pin_sync;
endmodule // serial_clock_pin

// [hw/serial_baud_rate_generator.sv]
// Rate generator top: AXI4-Lite register slave, divisor pair and serial clock selection
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module serial_baud_rate_generator (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Receiver status, same clock
	input wire logic receiver_idle_flag,
	// Serial clock pin
	input wire logic clock_pin_in,
	output logic clock_pin_out,
	output logic clock_pin_oe,
	// To the shifters
	output logic rate_tick,
	output logic serial_clock,
	output logic sync_mode_select,
	output logic high_speed_select,
	output logic port_enable
);
	rate_cfg_if cfg ();

	logic [7:0] baud_control;
	logic [7:0] receive_status_control;
	logic [7:0] rate_divisor_low_reg;
	logic [7:0] rate_divisor_high_reg;
	logic [7:0] transmit_status_control;
	logic [7:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic divisor_clear;

	// Write channel: address and data taken in either order, response after both
	wire logic aw_take = s_axi_awvalid && s_axi_awready;
	wire logic w_take = s_axi_wvalid && s_axi_wready;
	wire logic write_go = aw_held && w_held && !bvalid;
	wire logic lane0 = w_strb[0];
	wire logic [7:0] wbyte = w_data[7:0];
	wire logic sel_baud = (aw_addr == rate_gen_pkg::OFS_BAUD_CONTROL);
	wire logic sel_rx = (aw_addr == rate_gen_pkg::OFS_RECEIVE_STATUS_CONTROL);
	wire logic sel_low = (aw_addr == rate_gen_pkg::OFS_RATE_DIVISOR_LOW);
	wire logic sel_high = (aw_addr == rate_gen_pkg::OFS_RATE_DIVISOR_HIGH);
	wire logic sel_tx = (aw_addr == rate_gen_pkg::OFS_TRANSMIT_STATUS_CONTROL);
	wire logic sel_cnt = (aw_addr == rate_gen_pkg::OFS_RATE_COUNT_STATUS);
	wire logic w_mapped = sel_baud || sel_rx || sel_low || sel_high || sel_tx || sel_cnt;
	wire logic wr_baud = write_go && sel_baud && lane0;
	wire logic wr_rx = write_go && sel_rx && lane0;
	wire logic wr_low = write_go && sel_low && lane0;
	wire logic wr_high = write_go && sel_high && lane0;
	wire logic wr_tx = write_go && sel_tx && lane0;

	// Masked merges keep read-only bits at their held value
	wire logic [7:0] next_baud_control = (baud_control & ~rate_gen_pkg::BAUD_CONTROL_WMASK) |
		(wbyte & rate_gen_pkg::BAUD_CONTROL_WMASK);
	wire logic [7:0] next_receive_status_control =
		(receive_status_control & ~rate_gen_pkg::RECEIVE_STATUS_CONTROL_WMASK) |
		(wbyte & rate_gen_pkg::RECEIVE_STATUS_CONTROL_WMASK);
	wire logic [7:0] next_transmit_status_control =
		(transmit_status_control & ~rate_gen_pkg::TRANSMIT_STATUS_CONTROL_WMASK) |
		(wbyte & rate_gen_pkg::TRANSMIT_STATUS_CONTROL_WMASK);

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (aw_take) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (write_go) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (w_take) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (write_go) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= rate_gen_pkg::RESP_OKAY;
		end else if (write_go) begin
			bvalid <= 1'b1;
			bresp <= w_mapped ? rate_gen_pkg::RESP_OKAY : rate_gen_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid <= 1'b0;
		end
	end

	// Control registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			baud_control <= rate_gen_pkg::BAUD_CONTROL_RESET;
			receive_status_control <= rate_gen_pkg::RECEIVE_STATUS_CONTROL_RESET;
			transmit_status_control <= rate_gen_pkg::TRANSMIT_STATUS_CONTROL_RESET;
		end else begin
			if (wr_baud) begin
				baud_control <= next_baud_control;
			end
			if (wr_rx) begin
				receive_status_control <= next_receive_status_control;
			end
			if (wr_tx) begin
				transmit_status_control <= next_transmit_status_control;
			end
		end
	end

	// Divisor pair; any write restarts the timer so a new rate needs no old overflow
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rate_divisor_low_reg <= rate_gen_pkg::DIVISOR_RESET;
			rate_divisor_high_reg <= rate_gen_pkg::DIVISOR_RESET;
			divisor_clear <= 1'b0;
		end else begin
			if (wr_low) begin
				rate_divisor_low_reg <= wbyte;
			end
			if (wr_high) begin
				rate_divisor_high_reg <= wbyte;
			end
			divisor_clear <= wr_low || wr_high;
		end
	end

	// Read channel
	wire logic ar_take = s_axi_arvalid && s_axi_arready;
	wire logic rsel_baud = (s_axi_araddr == rate_gen_pkg::OFS_BAUD_CONTROL);
	wire logic rsel_rx = (s_axi_araddr == rate_gen_pkg::OFS_RECEIVE_STATUS_CONTROL);
	wire logic rsel_low = (s_axi_araddr == rate_gen_pkg::OFS_RATE_DIVISOR_LOW);
	wire logic rsel_high = (s_axi_araddr == rate_gen_pkg::OFS_RATE_DIVISOR_HIGH);
	wire logic rsel_tx = (s_axi_araddr == rate_gen_pkg::OFS_TRANSMIT_STATUS_CONTROL);
	wire logic rsel_cnt = (s_axi_araddr == rate_gen_pkg::OFS_RATE_COUNT_STATUS);
	wire logic r_mapped = rsel_baud || rsel_rx || rsel_low || rsel_high || rsel_tx || rsel_cnt;
	// Idle flag is live from the receiver; no transmitter here, so shift-empty reads set
	wire logic [7:0] baud_view = baud_control | (8'(receiver_idle_flag) << rate_gen_pkg::BIT_RECEIVER_IDLE);
	wire logic [7:0] tx_view = transmit_status_control | (8'h01 << rate_gen_pkg::BIT_SHIFT_EMPTY);
	wire logic [31:0] read_mux =
		rsel_baud ? {24'h000000, baud_view} :
		rsel_rx ? {24'h000000, receive_status_control} :
		rsel_low ? {24'h000000, rate_divisor_low_reg} :
		rsel_high ? {24'h000000, rate_divisor_high_reg} :
		rsel_tx ? {24'h000000, tx_view} :
		rsel_cnt ? {16'h0000, cfg.count} : 32'h00000000;

	assign s_axi_arready = !rvalid;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= rate_gen_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rvalid <= 1'b1;
			rdata <= read_mux;
			rresp <= r_mapped ? rate_gen_pkg::RESP_OKAY : rate_gen_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid <= 1'b0;
		end
	end

	// Configuration towards the counter
	assign cfg.divisor = {rate_divisor_high_reg, rate_divisor_low_reg};
	assign cfg.wide_counter_select = baud_control[rate_gen_pkg::BIT_WIDE_COUNTER];
	assign cfg.high_speed_select = transmit_status_control[rate_gen_pkg::BIT_HIGH_SPEED];
	assign cfg.sync_mode_select = transmit_status_control[rate_gen_pkg::BIT_SYNC_MODE];
	assign cfg.clear = divisor_clear;

	rate_counter u_counter (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cfg(cfg)
	);

	// Master drives the pin only in sync mode with the port enabled
	wire logic clock_master = cfg.sync_mode_select &&
		transmit_status_control[rate_gen_pkg::BIT_CLOCK_SOURCE] &&
		receive_status_control[rate_gen_pkg::BIT_PORT_ENABLE];

	serial_clock_pin u_pin (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.master(clock_master),
		.invert(baud_control[rate_gen_pkg::BIT_CLOCK_POLARITY]),
		.generated_level(cfg.clock_level),
		.clock_pin_in(clock_pin_in),
		.clock_pin_out(clock_pin_out),
		.clock_pin_oe(clock_pin_oe),
		.serial_clock(serial_clock)
	);

	assign rate_tick = cfg.tick;
	assign sync_mode_select = cfg.sync_mode_select;
	assign high_speed_select = cfg.high_speed_select;
	assign port_enable = receive_status_control[rate_gen_pkg::BIT_PORT_ENABLE];
endmodule // serial_baud_rate_generator

// [bench/serial_baud_rate_generator_sva.sv]
// Checker of bus handshakes, tick shape and serial clock pin drive
`timescale 1ns/10ps
module serial_baud_rate_generator_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Rate and pin
	input wire logic rate_tick,
	input wire logic clock_pin_in,
	input wire logic clock_pin_out,
	input wire logic clock_pin_oe,
	input wire logic serial_clock,
	input wire logic sync_mode_select,
	input wire logic port_enable
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_tick_pulse; rate_tick |=> !rate_tick; endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("tick wider than a cycle");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_b_done: assert property (p_b_done) else $error("write response repeated");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_busy: assert property (p_busy) else $error("write taken during response");
	property p_r_top; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0 && !s_axi_arready; endproperty
	a_r_top: assert property (p_r_top) else $error("read word malformed");
	property p_oe; clock_pin_oe |-> $past(sync_mode_select) && $past(port_enable); endproperty
	a_oe: assert property (p_oe) else $error("pin driven outside sync master");
	property p_master; clock_pin_oe && sync_mode_select |-> serial_clock == clock_pin_out; endproperty
	a_master: assert property (p_master) else $error("master clock not internal");
	// Slave clock is the pin two flops late; the guard skips the reset-loaded synchroniser
	property p_slave; !clock_pin_oe && $past(rst_n, 2) |-> serial_clock == $past(clock_pin_in, 2); endproperty
	a_slave: assert property (p_slave) else $error("slave clock not from pin");
endmodule // serial_baud_rate_generator_sva
bind serial_baud_rate_generator serial_baud_rate_generator_sva i_sva (.*);

// [bench/tb_serial_baud_rate_generator.sv]
// Self-checking bench for the rate generator registers and tick timing
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
$display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_serial_baud_rate_generator;
	logic clk_sys, rst_n, awv, wv, bready, arv, rready, awready, wready, bvalid, arready, rvalid;
	logic tick, sclk, pout, poe, sync, hs, pen;
	logic pin_in = 1'b0;
	logic idle = 1'b1;
	logic [7:0] awaddr, araddr, d, lo, hi;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	int num_errors, total_checks, p, c, k;
	logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
	logic [7:0] re [6] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
	serial_baud_rate_generator i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .receiver_idle_flag(idle),
		.clock_pin_in(pin_in), .clock_pin_out(pout), .clock_pin_oe(poe), .rate_tick(tick),
		.serial_clock(sclk), .sync_mode_select(sync), .high_speed_select(hs), .port_enable(pen));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Pin noise keeps the slave synchroniser busy
	always @(posedge clk_sys) begin
		pin_in <= 1'($urandom);
	end
	task conclude;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task fail_wait;
		num_errors++;
		conclude;
	endtask
	// Sampling at the falling edge avoids racing the slave's combinational readies
	task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
		int i;
		logic ga, gw, gb;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(negedge clk_sys);
			ga = awv && awready;
			gw = wv && wready;
			gb = bvalid;
			rs = bresp;
			@(posedge clk_sys);
			if (ga) awv <= 1'b0;
			if (gw) wv <= 1'b0;
			if (gb) break;
		end
		bready <= 1'b0;
		if (i == 200) fail_wait;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] rs);
		int i;
		logic ga, gb;
		@(posedge clk_sys);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(negedge clk_sys);
			ga = arv && arready;
			gb = rvalid;
			v = rdata[7:0];
			rs = rresp;
			@(posedge clk_sys);
			if (ga) arv <= 1'b0;
			if (gb) break;
		end
		rready <= 1'b0;
		if (i == 200) fail_wait;
	endtask
	task wait_tick;
		k = 0;
		do begin
			@(negedge clk_sys);
			k++;
		end while (tick !== 1'b1 && k < 20000);
		if (k >= 20000) fail_wait;
	endtask
	function automatic int mul(logic s, logic w, logic h);
		if (s) return 4;
		if (w) return h ? 4 : 16;
		return h ? 16 : 64;
	endfunction
	initial begin
		{awv, wv, bready, arv, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		rst_n = 1'b0;
		p = $urandom(27);
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (c = 0; c < 6; c++) begin
			rd(ra[c], d, r);
			`CHK("reset value", re[c], d)
			`CHK("read resp", 2'h0, r)
		end
		rd(8'h18, d, r);
		`CHK("unmapped read", 2'h2, r)
		wr(8'h18, 8'hff, r);
		`CHK("unmapped write", 2'h2, r)
		// Writable masks: baud 1b plus live idle, receive f8, transmit fd plus empty flag
		for (c = 0; c < 3; c++) begin
			wr((c == 1) ? ra[1] : ra[c * 2], 8'hff, r);
			rd((c == 1) ? ra[1] : ra[c * 2], d, r);
			`CHK("masked readback", (c == 0) ? 8'h5b : (c == 1) ? 8'hf8 : 8'hff, d)
		end
		// Software looks at the idle flag before touching the clock
		idle <= 1'b0;
		rd(8'h00, d, r);
		`CHK("idle flag", 8'h1b, d)
		idle <= 1'b1;
		wstrb <= 4'he;
		wr(8'h08, 8'h55, r);
		wstrb <= 4'hf;
		rd(8'h08, d, r);
		`CHK("strobe off", 8'h00, d)
		for (c = 0; c < 8; c++) begin
			lo = (c == 3) ? 8'hff : (c == 0) ? 8'h00 : 8'($urandom % 8);
			hi = 8'($urandom % 2);
			wr(8'h00, {4'h0, c[1], 3'h0}, r);
			wr(8'h10, {1'b1, 2'h0, c[2], 1'b0, c[0], 2'h0}, r);
			wr(8'h0c, hi, r);
			wr(8'h08, lo, r);
			p = mul(c[2], c[1], c[0]) * ((c[1] ? {hi, lo} : {8'h0, lo}) + 1);
			wait_tick;
			`CHK("first tick near", 1'b1, k >= p - 2 && k <= p + 1)
			wait_tick;
			`CHK("tick period", p, k)
			`CHK("pin drive", c[2], poe)
			`CHK("high speed", c[0], hs)
		end
		conclude;
	end
endmodule // tb_serial_baud_rate_generator
